// >>> inc/acr_pkg.sv
// Purpose: Shared constants and types for the converter config block
// Assumes: APB registers, one word each, byte address = index * 4
// Notes:   Reset values are the power-on values of each register
package acr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_STATE  = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_RESULT = 4'h2;
  localparam logic [3:0] IDX_ANALOG = 4'h3;
  localparam logic [3:0] IDX_CONV   = 4'h4;

  // Reset values
  localparam logic [7:0] RST_ANALOG = 8'h8B;
  localparam logic [7:0] RST_CONV   = 8'h00;
  localparam logic [1:0] RST_STATE  = 2'h0;

  // Field positions, analog setup register
  localparam int BIAS_LSB = 6;
  localparam int GAIN_LSB = 3;
  localparam int AZ_BIT   = 2;

  // Field positions, conversion setup register
  localparam int MODE_LSB  = 6;
  localparam int FMT_LSB   = 4;
  localparam int CRCW_BIT  = 3;
  localparam int CRCEN_BIT = 2;
  localparam int OFF_BIT   = 1;
  localparam int GCAL_BIT  = 0;

  // Conversion mode field and converter state codes
  localparam logic [1:0] MODE_CONT   = 2'h3;
  localparam logic [1:0] MODE_STBY   = 2'h2;
  localparam logic [1:0] ST_CONVERT  = 2'h3;
  localparam logic [1:0] ST_STANDBY  = 2'h2;
  localparam logic [1:0] ST_SHUTDOWN = 2'h0;

  // Analog x16 gain code, then the codes with digital multiply behind analog x16
  localparam logic [2:0] GAIN_X16 = 3'h5;
  localparam logic [2:0] GAIN_X32 = 3'h6;
  localparam logic [2:0] GAIN_X64 = 3'h7;

  // Saturation codes for the formats without overrange
  localparam logic [23:0] SAT_HI = 24'hFFFFFF;
  localparam logic [23:0] SAT_LO = 24'h800000;

  typedef enum logic [1:0] {
    ACR_FMT_24   = 2'h0,
    ACR_FMT_LEFT = 2'h1,
    ACR_FMT_SIGN = 2'h2,
    ACR_FMT_TAG  = 2'h3
  } acr_fmt_t;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'h0,
    ACR_CONV = 2'h1,
    ACR_GAP  = 2'h3
  } acr_fsm_t;

  // Configuration frozen for one conversion
  typedef struct packed {
    logic [2:0] gain;
    logic [1:0] mode;
    acr_fmt_t   fmt;
    logic       az;
  } acr_cfg_t;

  // Raw filter output, 26-bit signed with overrange headroom
  typedef struct packed {
    logic [25:0] data;
    logic [3:0]  chan;
    logic        last;
  } acr_sample_t;

  // Analog front-end controls
  typedef struct packed {
    logic [1:0] bias;
    logic [2:0] again;
    logic [1:0] dshift;
    logic       az;
  } acr_analog_t;

  // Formatted result word
  typedef struct packed {
    logic [31:0] data;
    logic        wide;
    logic        valid;
  } acr_result_t;

endpackage

// >>> logic/acr_top.sv
// Purpose: Analog and conversion setup registers, conversion sequencing
//          and output word formatting for a delta-sigma converter
// Assumes: Filter sample presented at end of conversion, same clock
// Notes:   APB slave with zero wait states, read data from flip-flops
//
// Overview of operation
// - Analog setup register, 8-bit RW at index 3, resets to 8'h8B.
// - Bits 7-6 select bias current multiplier x0.5 to x2.
// - Bits 5-3 select gain from x1/3 up to x16.
// - Gain codes 110 and 111 are analog x16 with digital x2 and x4.
// - Auto-zero bit set doubles every conversion time.
// - With auto-zero, continuous runs as back-to-back single conversions.
// - Conversion setup register, 8-bit RW at index 4, resets to zero.
// - Mode 11 converts continuously, repeating scan cycles.
// - Mode 10 does one conversion or cycle, then state becomes standby.
// - Mode 0x does one conversion or cycle, then state becomes shutdown.
// - Layout 00 gives 24-bit result saturated to FFFFFF or 800000.
// - Layout 01 gives left-justified 24 bits plus zero byte, saturated.
// - Layout 10 gives eight sign bits above the 24-bit result.
// - Layout 11 gives channel tag, four sign bits, 24-bit result.
// - Bit 3 selects 32-bit read checksum instead of 16-bit.
// - Bit 2 enables read checksum, not touching config checksum.
// - Bit 1 enables digital offset correction.
// - Bit 0 enables digital gain correction.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module acr_top #(
  parameter int CONV_CYCLES = 64  // Cycles of one plain conversion
) (
  input  wire logic                 pclk,          // APB clock, 40 MHz
  input  wire logic                 presetn,       // Async reset, low
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB access phase
  input  wire logic                 pwrite,        // APB write
  input  wire logic [11:0]          paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic                      pready,        // APB ready
  output logic [31:0]               prdata,        // APB read data
  output logic                      pslverr,       // APB error
  input  wire logic                 scan_en,       // Sequencer active
  input  wire acr_pkg::acr_sample_t sample,        // Filter output
  output acr_pkg::acr_analog_t      analog_ctl,    // Front-end controls
  output logic                      crc_read_en,   // Read checksum on
  output logic                      crc_read_wide, // 32-bit checksum
  output logic                      offset_corr_en,// Offset correction
  output logic                      gain_corr_en,  // Gain correction
  output logic                      busy,          // Conversion running
  output acr_pkg::acr_result_t      result         // Formatted result
);
  import acr_pkg::*;

  // Counter is 16 bits wide and must hold twice the conversion length.
  // Checked at elaboration so a bad length never reaches silicon;
  // a zero length would wrap the last counter value round to all ones.
  if (CONV_CYCLES < 1 || CONV_CYCLES > 32767) begin : g_len_check
    $error("CONV_CYCLES out of range");
  end

  // Last counter values of a plain and of an auto-zeroed conversion.
  // The counter starts at zero, so both are one below the length;
  // auto-zero runs each conversion twice as long.
  localparam logic [15:0] LEN_1 = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] LEN_2 = 16'(2 * CONV_CYCLES - 1);

  // Whole module state in one record: registers, sequencer, bus answer.
  // The frozen cfg copy keeps gain, mode, layout and length of a running conversion immune to writes.

  typedef struct packed {
    logic [7:0]  analog;
    logic [7:0]  conv;
    logic [1:0]  state;
    acr_fsm_t    fsm;
    logic [15:0] cnt;
    acr_cfg_t    cfg;
    acr_result_t res;
    logic [31:0] rdata;
    logic        err;
  } acr_st_t;

  acr_st_t s_q;
  acr_st_t s_d;

  logic [3:0]  idx;
  logic        mapped;
  logic        setup;
  logic        wr_acc;
  logic [15:0] last_cnt;
  acr_cfg_t    cfg_now;
  logic [1:0]  shift_of;
  logic [27:0] scaled;
  logic        cycle_end;

  // Address decode; only aligned words inside the first five slots hit.
  // Upper address bits must be zero so aliases never reach a register.
  assign idx    = paddr[5:2];
  assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                  (idx <= IDX_CONV);
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && mapped;

  // Live configuration, frozen into cfg at each conversion start.
  // Only these four fields shape a result; the enables act at once.
  always_comb begin
    cfg_now.gain = s_q.analog[GAIN_LSB +: 3];
    cfg_now.mode = s_q.conv[MODE_LSB +: 2];
    cfg_now.fmt  = acr_fmt_t'(s_q.conv[FMT_LSB +: 2]);
    cfg_now.az   = s_q.analog[AZ_BIT];
  end

  // digital shift
  // Digital gain is a plain left shift, cheaper than a multiplier;
  // the extra headroom bits of the raw word absorb the growth.
  always_comb begin
    unique case (s_q.cfg.gain)
      GAIN_X32: shift_of = 2'h1;
      GAIN_X64: shift_of = 2'h2;
      default:  shift_of = 2'h0;
    endcase
  end

  assign last_cnt = s_q.cfg.az ? LEN_2 : LEN_1;

  // A one-shot ends at the last channel of a scan, or at once without scan
  assign cycle_end = !scan_en || sample.last;

  // Digital gain on the sign-extended raw sample
  assign scaled = {{2{sample.data[25]}}, sample.data} << shift_of;

  // Clamp to a signed 25-bit range for the sign-filled layouts.
  // Overrange survives in the sign bits, but only up to one extra bit;
  // anything beyond that would wrap, so it is pinned to the limit.
  function automatic logic [24:0] clamp25(input logic [27:0] v);
    logic hi;
    logic lo;
    hi = !v[27] && (v[26:24] != 3'h0);
    lo = v[27] && (v[26:24] != 3'h7);
    if (hi) begin
      clamp25 = 25'h0FFFFFF;
    end else if (lo) begin
      clamp25 = 25'h1000000;
    end else begin
      clamp25 = v[24:0];
    end
  endfunction

  // Saturate to 24 bits for the layouts without overrange.
  // The positive limit is all ones, so software sees no sign there;
  // that is the documented coding and is kept as is.
  function automatic logic [23:0] sat24(input logic [27:0] v);
    logic hi;
    logic lo;
    hi = !v[27] && (v[26:23] != 4'h0);
    lo = v[27] && (v[26:23] != 4'hF);
    if (hi) begin
      sat24 = SAT_HI;
    end else if (lo) begin
      sat24 = SAT_LO;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // Build the output word in the layout frozen for this conversion.
  // All four layouts are complete, so no default branch is needed.
  function automatic logic [31:0] fmt_word(input acr_fmt_t f,
                                           input logic [27:0] v,
                                           input logic [3:0] ch);
    logic [24:0] c;
    c = clamp25(v);
    unique case (f)
      ACR_FMT_24:   fmt_word = {8'h00, sat24(v)};
      ACR_FMT_LEFT: fmt_word = {sat24(v), 8'h00};
      ACR_FMT_SIGN: fmt_word = {{8{c[24]}}, c[23:0]};
      ACR_FMT_TAG:  fmt_word = {ch, {4{c[24]}}, c[23:0]};
    endcase
  endfunction

  // Next-state logic for registers, sequencer and bus answer
  always_comb begin
    s_d           = s_q;
    s_d.res.valid = 1'b0;

    // Read data is fetched in the setup phase so the access needs no wait.
    // A side effect: a register changing in the setup cycle itself is
    // reported with its value from before that change.
    // Unmapped reads return zero and raise the error flag.
    if (setup) begin
      s_d.err   = !mapped;
      s_d.rdata = 32'h00000000;
      if (mapped && !pwrite) begin
        unique case (idx)
          IDX_STATE:  s_d.rdata = {30'h0, s_q.state};
          IDX_STATUS: s_d.rdata = {29'h0, s_q.res.wide,
                                   s_q.fsm == ACR_GAP,
                                   s_q.fsm != ACR_IDLE};
          IDX_RESULT: s_d.rdata = s_q.res.data;
          IDX_ANALOG: s_d.rdata = {24'h0, s_q.analog};
          IDX_CONV:   s_d.rdata = {24'h0, s_q.conv};
          default:    s_d.rdata = 32'h00000000;
        endcase
      end
    end

    // Software writes; low analog bits are stored as written.
    // Status and result slots are read-only and ignore writes.
    if (wr_acc) begin
      unique case (idx)
        IDX_STATE:  s_d.state = pwdata[1:0];
        IDX_ANALOG: s_d.analog = pwdata[7:0];
        IDX_CONV:   s_d.conv = pwdata[7:0];
        default:    s_d.analog = s_q.analog;
      endcase
    end

    // Sequencer; a hardware state update wins over a software write.
    // It is evaluated after the bus writes so its assignments override.
    // Idle waits for the convert code; conv counts one conversion;
    // gap is the single dead cycle between auto-zeroed continuous conversions.
    unique case (s_q.fsm)
      ACR_IDLE: begin
        if (s_q.state == ST_CONVERT) begin
          s_d.cfg = cfg_now;
          s_d.cnt = 16'h0000;
          s_d.fsm = ACR_CONV;
        end
      end
      ACR_CONV: begin
        if (s_q.state != ST_CONVERT) begin
          // Aborted by software leaving the convert state
          s_d.fsm = ACR_IDLE;
        end else if (s_q.cnt != last_cnt) begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end else begin
          s_d.res.data  = fmt_word(s_q.cfg.fmt, scaled, sample.chan);
          s_d.res.wide  = s_q.cfg.fmt != ACR_FMT_24;
          s_d.res.valid = 1'b1;
          s_d.cnt       = 16'h0000;
          if (s_q.cfg.mode == MODE_CONT && !s_q.cfg.az) begin
            s_d.cfg = cfg_now;
          end else if (s_q.cfg.mode == MODE_CONT) begin
            s_d.fsm = ACR_GAP;
          end else if (!cycle_end) begin
            // Scan not finished yet, next channel under new settings
            s_d.cfg = cfg_now;
          end else if (s_q.cfg.mode == MODE_STBY) begin
            s_d.state = ST_STANDBY;
            s_d.fsm   = ACR_IDLE;
          end else begin
            s_d.state = ST_SHUTDOWN;
            s_d.fsm   = ACR_IDLE;
          end
        end
      end
      ACR_GAP: begin
        // One idle cycle separates the single conversions of a series
        s_d.cfg = cfg_now;
        s_d.fsm = (s_q.state == ST_CONVERT) ? ACR_CONV : ACR_IDLE;
      end
      default: s_d.fsm = ACR_IDLE;
    endcase
  end

  // State register
  // Reset loads only constants; the registers come up at their
  // power-on values and the sequencer starts idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.analog <= RST_ANALOG;
      s_q.conv   <= RST_CONV;
      s_q.state  <= RST_STATE;
      s_q.fsm    <= ACR_IDLE;
      s_q.cnt    <= 16'h0000;
      s_q.cfg    <= '0;
      s_q.res    <= '0;
      s_q.rdata  <= 32'h00000000;
      s_q.err    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answer: always ready, error held from the setup phase.
  // Zero wait states keep the bus simple; the price is that read data
  // must be ready one cycle early, which the setup fetch provides.
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = psel && penable && s_q.err;

  // Front-end controls. Bias and auto-zero follow the register live,
  // gain follows the frozen copy so it cannot change mid-conversion.
  // bias select
  assign analog_ctl.bias   = s_q.analog[BIAS_LSB +: 2];
  // analog gain, capped at x16 for the digital codes
  assign analog_ctl.again  = (s_q.cfg.gain > GAIN_X16) ? GAIN_X16 : s_q.cfg.gain;
  assign analog_ctl.dshift = shift_of;
  assign analog_ctl.az     = s_q.analog[AZ_BIT];

  // Checksum and correction enables act at once on the serial side;
  // the checksum and the corrections themselves are downstream.
  // checksum width
  assign crc_read_wide  = s_q.conv[CRCW_BIT];
  assign crc_read_en    = s_q.conv[CRCEN_BIT];
  assign offset_corr_en = s_q.conv[OFF_BIT];
  assign gain_corr_en   = s_q.conv[GCAL_BIT];

  // Busy covers the gap cycle too, so a series reads as one activity
  assign busy   = s_q.fsm != ACR_IDLE;
  assign result = s_q.res;

endmodule

// >>> verification/acr_top_checker.sv
// Purpose: Port-level checks for the converter config block
// Assumes: Writes land at the APB access edge
// Notes:   Conversion lengths scale with CONV_CYCLES
`timescale 1ns/1ps
module acr_top_checker #(
  parameter int CONV_CYCLES = 64 // Plain conversion length
) (
  input wire logic                 pclk,           // Clock
  input wire logic                 presetn,        // Reset, low
  input wire logic                 psel,           // Select
  input wire logic                 penable,        // Access phase
  input wire logic                 pwrite,         // Write
  input wire logic [11:0]          paddr,          // Address
  input wire logic [31:0]          pwdata,         // Write data
  input wire logic                 pready,         // Ready
  input wire logic [31:0]          prdata,         // Read data
  input wire logic                 pslverr,        // Error
  input wire logic                 scan_en,        // Sequencer on
  input wire acr_pkg::acr_sample_t sample,         // Raw sample
  input wire acr_pkg::acr_analog_t analog_ctl,     // Front end
  input wire logic                 crc_read_en,    // Checksum on
  input wire logic                 crc_read_wide,  // Wide checksum
  input wire logic                 offset_corr_en, // Offset corr
  input wire logic                 gain_corr_en,   // Gain corr
  input wire logic                 busy,           // Running
  input wire acr_pkg::acr_result_t result          // Result word
);
  import acr_pkg::*;
  localparam int LEN1 = CONV_CYCLES;
  localparam int LEN2 = 2 * CONV_CYCLES;
  localparam int LEN3 = 2 * CONV_CYCLES + 1;
  logic wr_an;
  logic wr_cv;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes to each setup register
  assign wr_an = psel && penable && pwrite && (paddr == 12'h00C);
  assign wr_cv = psel && penable && pwrite && (paddr == 12'h010);
  // Control fields follow the written word
  property p_bias; wr_an |=> analog_ctl.bias == $past(pwdata[7:6]); endproperty
  a_bias: assert property (p_bias) else $error("bias not written");
  property p_az; wr_an |=> analog_ctl.az == $past(pwdata[2]); endproperty
  a_az: assert property (p_az) else $error("autozero not written");
  property p_en; wr_cv |=> {crc_read_wide, crc_read_en, offset_corr_en, gain_corr_en}
    == $past(pwdata[3:0]); endproperty
  a_en: assert property (p_en) else $error("enables not written");
  // Digital multiply only behind full analog gain
  property p_dig; analog_ctl.dshift != 2'h0 |-> analog_ctl.again == GAIN_X16; endproperty
  a_dig: assert property (p_dig) else $error("digital gain without x16");
  // Conversion length, doubled by auto-zero
  property p_one; $rose(busy) && !analog_ctl.az |-> ##LEN1 result.valid; endproperty
  a_one: assert property (p_one) else $error("plain conversion length");
  property p_two; $rose(busy) && analog_ctl.az |-> ##LEN2 result.valid; endproperty
  a_two: assert property (p_two) else $error("autozero conversion length");
  // Continuous repeats, auto-zero adds a gap; abort ends the wait
  property p_cont; result.valid && busy && !analog_ctl.az |-> ##LEN1 (result.valid || !busy);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous period");
  property p_rep; result.valid && busy && analog_ctl.az |-> ##LEN3 (result.valid || !busy);
  endproperty
  a_rep: assert property (p_rep) else $error("autozero repeat period");
  c_wide: cover property (result.valid && result.wide);
  c_x64: cover property (analog_ctl.dshift == 2'h2);
  c_cont: cover property (result.valid && busy);
endmodule

// >>> verification/acr_top_tb_top.sv
// Purpose: Self-checking bench for the converter config block
// Assumes: Zero-wait APB slave, short conversions
// Notes:   Sequencer input held low, outside the scan test, so single modes end at once
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module acr_top_tb_top;
  import acr_pkg::*;
  localparam int CC = 4;
  localparam logic [31:0] POS [4] = '{32'h00FFFFFF, 32'hFFFFFF00, 32'h00800000, 32'hA0800000};
  localparam logic [31:0] NEG [4] = '{32'h00800000, 32'h80000000, 32'hFF000000, 32'hAF000000};
  logic        pclk, presetn, psel, penable, pwrite, scan_en, er;
  logic        pready, pslverr, crc_read_en, crc_read_wide, offset_corr_en, gain_corr_en, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  acr_sample_t sample;
  acr_analog_t analog_ctl;
  acr_result_t result;
  int          errors, tests_run, nv;
  acr_top #(.CONV_CYCLES(CC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scan_en(scan_en), .sample(sample),
    .analog_ctl(analog_ctl), .crc_read_en(crc_read_en), .crc_read_wide(crc_read_wide),
    .offset_corr_en(offset_corr_en), .gain_corr_en(gain_corr_en), .busy(busy),
    .result(result));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic test_done;
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One APB transfer, then an idle cycle so psel never toggles twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin errors++; test_done(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (result.valid !== 1'b1 && n < 100);
    if (result.valid !== 1'b1) begin errors++; test_done(); end
  endtask
  // Configure, start, time and judge one conversion
  task automatic conv(input logic [1:0] md, input logic az, input logic [1:0] fm,
                      input logic [2:0] g, input logic [25:0] dt, input logic [31:0] ex);
    int n;
    sample <= '{data: dt, chan: 4'hA, last: 1'b0};
    apb(1'b1, 12'h00C, {24'h0, g[1:0], g, az, 2'b11});
    apb(1'b1, 12'h010, {24'h0, md, fm, 4'h0});
    apb(1'b1, 12'h000, 32'h3);
    wait_valid(n);
    `CHK("latency", az ? 2 * CC + 1 : CC + 1, n)
    `CHK("word", ex, result.data)
    `CHK("wide", fm != 2'h0, result.wide)
    `CHK("bias", g[1:0], analog_ctl.bias)
    `CHK("again", (g > 3'h5) ? 3'h5 : g, analog_ctl.again)
    `CHK("dshift", (g == 3'h7) ? 2'h2 : (g == 3'h6) ? 2'h1 : 2'h0, analog_ctl.dshift)
    if (md == 2'b11) begin
      wait_valid(n);
      `CHK("period", az ? 2 * CC + 1 : CC, n)
      apb(1'b1, 12'h000, 32'h0);
    end
    apb(1'b0, 12'h000, 32'h0);
    `CHK("state", (md == 2'b10) ? 32'h2 : 32'h0, rd)
    `CHK("busy", 1'b0, busy)
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; scan_en = 1'b0; sample = '0; errors = 0; tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Power-on values, then an unmapped slot
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("analog", 32'h0000008B, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("convset", 32'h00000000, rd)
    apb(1'b1, 12'h014, 32'hFF);
    `CHK("slverr", 1'b1, er)
    // Low setup bits reach their enables in order
    apb(1'b1, 12'h010, 32'h0000000F);
    `CHK("enables", 4'hF, {crc_read_wide, crc_read_en, offset_corr_en, gain_corr_en})
    apb(1'b1, 12'h010, 32'h00000005);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("readback", 32'h00000005, rd)
    `CHK("enables", 4'h5, {crc_read_wide, crc_read_en, offset_corr_en, gain_corr_en})
    // Every gain code, digital multiply on a unit sample
    for (int g = 0; g < 8; g++) begin
      conv(2'b00, 1'b0, 2'b00, 3'(g), 26'h1, {8'h0, 24'h1 << ((g == 7) ? 2 : (g == 6) ? 1 : 0)});
    end
    // Every layout on both overrange ends
    for (int f = 0; f < 4; f++) begin
      conv(2'b10, 1'b0, 2'(f), 3'h1, 26'h0800000, POS[f]);
      conv(2'b01, 1'b0, 2'(f), 3'h1, 26'h3000000, NEG[f]);
    end
    // Continuous, plain then auto-zeroed, stopped by software
    conv(2'b11, 1'b0, 2'b10, 3'h1, 26'h0000010, 32'h00000010);
    conv(2'b11, 1'b1, 2'b10, 3'h1, 26'h3FFFFF0, 32'hFFFFFFF0);
    // Scan one-shot: stays converting until the last channel is flagged
    scan_en <= 1'b1;
    sample <= '{data: 26'h1, chan: 4'h3, last: 1'b0};
    apb(1'b1, 12'h010, 32'h00000080);
    apb(1'b1, 12'h000, 32'h3);
    wait_valid(nv);
    sample.last <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("scan state", 32'h3, rd)
    wait_valid(nv);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("scan end", 32'h2, rd)
    scan_en <= 1'b0;
    test_done();
  end
endmodule
bind acr_top acr_top_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .scan_en(scan_en), .sample(sample),
  .analog_ctl(analog_ctl), .crc_read_en(crc_read_en), .crc_read_wide(crc_read_wide),
  .offset_corr_en(offset_corr_en), .gain_corr_en(gain_corr_en), .busy(busy), .result(result));
